/* File: verilog/pdh_pkg.sv */
// Package for the power-down hold block: timing constants and pin group types.
// Assumes a single 25 MHz system clock.
package pdh_pkg;
	localparam int CLK_MHZ       = 25;
	localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
	// Slowest-grade ignore delay after the power-down pin rises, longest time
	localparam int IGNORE_NS     = 35;
	localparam int IGNORE_CYC_R  = (IGNORE_NS / CLK_PERIOD_NS);
	localparam int IGNORE_CYC    = (IGNORE_CYC_R < 1) ? 1 : IGNORE_CYC_R;
	// Resume time after the pin falls, longest time
	localparam int RESUME_US     = 1;
	localparam int RESUME_CYC_R  = (RESUME_US * 1000) / CLK_PERIOD_NS;
	localparam int RESUME_CYC    = (RESUME_CYC_R < 1) ? 1 : RESUME_CYC_R;
	localparam int CNT_W         = 6;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

	typedef enum {ST_RUN, ST_HOLD, ST_RESUME} pdh_state_type;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] oe;
	} pdh_pins_type;
endpackage

/* File: verilog/pdh_hold.sv */
// Power-down hold logic: freezes the user-side pin group while power-down is asserted.
// Assumes inputs synchronous to clock; user logic behind it honours the run enable.
//
// How it works
// - Pin high enters power-down when option set
// - Outputs and internal state held during power-down
// - Tristated outputs stay tristated while held
// - All inputs except power pin blocked
// - Pin hold latches keep last input level
// - Enable is a static parameter, fixed
// - Power pin not passed as array input
// - Inputs ignored within one cycle of rise
// - Inputs and outputs valid within 1 us; here they update 27 cycles (1080 ns) after the pin falls
// - Clocks and enables recognised within 1 us; here from the 27th edge (1080 ns) after the pin falls
`timescale 1ns/1ps
module pdh_hold
	import pdh_pkg::*;
#(
	parameter bit PD_ENABLE = 1'b1
) (
	input  wire logic         clock,          // System clock
	input  wire logic         rst,            // Async reset, high
	input  wire logic         power_down_pin, // Power-down control pin
	input  wire pdh_pins_type core_out,       // Outputs and enables from user logic
	input  wire logic [7:0]   pin_in,         // Dedicated and I/O pin inputs
	input  wire logic         pin_clk_en,     // Clock enable from pins or terms
	output pdh_pins_type      pad_out,        // Held outputs and enables to pads
	output logic [7:0]        core_in,        // Held inputs to user logic
	output logic              core_clk_en,    // Clock enable reaching user registers
	output logic              array_pd_in,    // Power pin as array input
	output logic              powered_down    // Power-down state
);
	pdh_state_type   state_q;
	logic [CNT_W-1:0] cnt_q;
	pdh_pins_type    pad_q;
	logic [7:0]      in_q;
	logic            run;
	logic            pd_req;

	assign pd_req = PD_ENABLE && power_down_pin;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= ST_RUN;
			cnt_q   <= CNT_ZERO;
		end else begin
			case (state_q)
				ST_RUN: begin
					if (pd_req) begin
						state_q <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (!pd_req) begin
						state_q <= ST_RESUME;
						cnt_q   <= CNT_ZERO;
					end
				end
				ST_RESUME: begin
					if (pd_req) begin
						state_q <= ST_HOLD;
					end else if (cnt_q == CNT_W'(RESUME_CYC - 1)) begin
						state_q <= ST_RUN;
					end else begin
						cnt_q <= cnt_q + CNT_ONE;
					end
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	// Run only when pd_req is low and the resume window has finished
	assign run = (state_q == ST_RUN) && !pd_req;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pad_q <= '0;
		end else if (run) begin
			pad_q <= core_out;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			in_q <= 8'h00;
		end else if (run) begin
			in_q <= pin_in;
		end
	end

	assign pad_out      = pad_q;
	assign core_in      = in_q;
	assign core_clk_en  = run && pin_clk_en;
	assign array_pd_in  = PD_ENABLE ? 1'b0 : power_down_pin;
	assign powered_down = (state_q != ST_RUN);

	chk_hold_outputs: assert property (@(posedge clock) disable iff (rst)
		(state_q == ST_HOLD) && $past(state_q == ST_HOLD) |-> $stable(pad_out))
		else $error("pad outputs changed while held");
	chk_hiz_kept: assert property (@(posedge clock) disable iff (rst)
		(state_q == ST_HOLD) && $past(state_q == ST_HOLD) |-> pad_out.oe == $past(pad_out.oe))
		else $error("output enable changed while held");
	chk_inputs_blocked: assert property (@(posedge clock) disable iff (rst)
		pd_req |=> $stable(core_in))
		else $error("inputs passed during power-down");
	chk_clock_blocked: assert property (@(posedge clock) disable iff (rst)
		pd_req |-> !core_clk_en)
		else $error("clock enable passed during power-down");
	chk_enter_hold: assert property (@(posedge clock) disable iff (rst)
		pd_req |=> powered_down)
		else $error("power-down not entered");
	// Pin released while holding, then eight quiet cycles
	sequence seq_release_in_hold;
		$fell(pd_req) && (state_q == ST_HOLD);
	endsequence

	sequence seq_pin_quiet;
		(!pd_req) [*8];
	endsequence

	// Resume lasts the counted window; a new request may cut it short
	chk_resume_time: assert property (@(posedge clock) disable iff (rst)
		seq_release_in_hold ##1 seq_pin_quiet ##1 seq_pin_quiet ##1 seq_pin_quiet
		|-> ##[0:2] (run || pd_req))
		else $error("resume took too long");
	chk_resume_not_early: assert property (@(posedge clock) disable iff (rst)
		seq_release_in_hold ##1 seq_pin_quiet |-> !run)
		else $error("resume ended before window");
	chk_reenter_hold: assert property (@(posedge clock) disable iff (rst)
		(state_q == ST_RESUME) && pd_req |=> (state_q == ST_HOLD))
		else $error("request during resume not held");
	chk_resume_count: assert property (@(posedge clock) disable iff (rst)
		(state_q == ST_RESUME) && !pd_req && (cnt_q != CNT_W'(RESUME_CYC - 1))
		|=> (state_q == ST_RESUME))
		else $error("resume window cut short");
	chk_run_capture: assert property (@(posedge clock) disable iff (rst)
		run |=> (pad_out == $past(core_out)) && (core_in == $past(pin_in)))
		else $error("running path not captured");
	chk_hold_frozen: assert property (@(posedge clock) disable iff (rst)
		(state_q != ST_RUN) |=> $stable(core_in) && $stable(pad_out))
		else $error("held values moved");
	chk_clock_passed: assert property (@(posedge clock) disable iff (rst)
		run |-> (core_clk_en == pin_clk_en))
		else $error("clock enable not passed while running");
	chk_option_off: assert property (@(posedge clock) disable iff (rst)
		!PD_ENABLE |-> !powered_down)
		else $error("power-down entered with option off");
	chk_array_input: assert property (@(posedge clock) disable iff (rst)
		PD_ENABLE |-> !array_pd_in)
		else $error("power pin reached array");
	chk_capture_value: assert property (@(posedge clock) disable iff (rst)
		run ##1 pd_req |-> pad_out == $past(core_out, 2) || pad_out == $past(core_out))
		else $error("held value not taken at rise");
endmodule

/* File: sim/pdh_sys_model.sv */
// System logic that drives the power-down pin of the hold block.
// Assumes the bench sets inputs in the same cycle that it asks for power-down.
`timescale 1ns/1ps
module pdh_sys_model (
	input  wire logic clock,          // System clock
	input  wire logic sleep_req,      // Bench request to power down
	output logic      power_down_pin  // Power-down pin to device
);
	initial power_down_pin = 1'b0;
	// Pin lags request one cycle so inputs are valid 40 ns early
	always @(posedge clock) power_down_pin <= sleep_req;
endmodule

/* File: sim/pin_power_down_hold_tb_top.sv */
// Self-checking bench for the power-down hold block.
// Assumes the partner model raises the pin one cycle after the request.
`timescale 1ns/1ps
module pin_power_down_hold_tb_top;
	import pdh_pkg::*;
	logic         clock, rst, sleep_req, power_down_pin, pin_clk_en, core_clk_en;
	logic         array_pd_in, powered_down;
	logic [7:0]   pin_in, core_in, held_in;
	pdh_pins_type core_out, pad_out, held_out;
	int           bad_count, checked, i;
	pdh_hold dut_u (.clock(clock), .rst(rst), .power_down_pin(power_down_pin),
		.core_out(core_out), .pin_in(pin_in), .pin_clk_en(pin_clk_en), .pad_out(pad_out),
		.core_in(core_in), .core_clk_en(core_clk_en), .array_pd_in(array_pd_in),
		.powered_down(powered_down));
	pdh_sys_model sys_u (.clock(clock), .sleep_req(sleep_req), .power_down_pin(power_down_pin));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rnd;
		core_out = pdh_pins_type'($urandom);
		pin_in = 8'($urandom);
		pin_clk_en = 1'($urandom);
	endtask
	// Pads follow the core while live, otherwise keep the held copy
	function automatic pdh_pins_type exp_pins(input bit live, input pdh_pins_type now,
		input pdh_pins_type held);
		return live ? now : held;
	endfunction
	task automatic print_verdict;
		$display("bad_count=%0d checked=%0d", bad_count, checked);
		if (bad_count == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		{rst, sleep_req, pin_clk_en, core_out, pin_in} = {2'h2, 1'b1, 24'h0};
		{bad_count, checked} = 0;
		void'($urandom(7));
		cyc(20);
		rst = 1'b0;
		for (i = 0; i < 6; i++) begin
			rnd();
			if (i == 0) core_out.oe = 8'h00;
			cyc(2);
			cmp(pad_out, core_out);
			cmp({8'h00, core_in}, {8'h00, pin_in});
			{held_out, held_in, sleep_req} = {core_out, pin_in, 1'b1};
			cyc(1);
			rnd();
			pin_clk_en = 1'b1;
			cmp({15'h0, core_clk_en}, 16'h0000);
			cyc(3);
			cmp(pad_out, held_out);
			cmp({core_in, 6'h0, powered_down, array_pd_in}, {held_in, 8'h02});
			sleep_req = 1'b0;
			cyc(1);
			rnd();
			cyc(20);
			cmp({pad_out.data, core_in}, {held_out.data, held_in});
			cmp({15'h0, powered_down}, 16'h0001);
			cyc(10);
			cmp(pad_out, core_out);
			cmp({core_in, 7'h0, core_clk_en}, {pin_in, 7'h0, pin_clk_en});
		end
		// Request again in mid-resume: back to hold, window restarts
		rnd();
		cyc(2);
		{held_out, held_in, sleep_req} = {core_out, pin_in, 1'b1};
		cyc(4);
		sleep_req = 1'b0;
		cyc(1);
		rnd();
		cyc(11);
		cmp({15'h0, powered_down}, 16'h0001);
		sleep_req = 1'b1;
		cyc(3);
		cmp(pad_out, exp_pins(1'b0, core_out, held_out));
		sleep_req = 1'b0;
		cyc(20);
		cmp({pad_out, core_in}, {exp_pins(1'b0, core_out, held_out), held_in});
		cyc(10);
		cmp(pad_out, exp_pins(1'b1, core_out, held_out));
		// Reset in mid-run clears the held copies, then capture restarts
		rst = 1'b1;
		cyc(1);
		cmp({pad_out.data, core_in}, {8'h00, 8'h00});
		cmp({15'h0, powered_down}, 16'h0000);
		rst = 1'b0;
		cyc(2);
		cmp(pad_out, exp_pins(1'b1, core_out, held_out));
		cmp({8'h00, core_in}, {8'h00, pin_in});
		print_verdict();
	end
endmodule
